// ===== design/clk_mgmt_pkg.sv
package clk_mgmt_pkg;

	// core clock and timing
	localparam int CORE_CLK_MHZ     = 100;
	localparam int XTAL_STARTUP_US  = 1000;
	localparam int RESUS_TIMEOUT_NS = 2000;
	localparam int FC_WINDOW_NS     = 10000;
	localparam int CORE_PERIOD_NS   = 1000 / CORE_CLK_MHZ;
	localparam int XTAL_STARTUP_CYC = XTAL_STARTUP_US * CORE_CLK_MHZ;
	localparam int RESUS_CYC        = RESUS_TIMEOUT_NS / CORE_PERIOD_NS;
	localparam int FC_WINDOW_CYC    = FC_WINDOW_NS / CORE_PERIOD_NS;
	localparam int GEN_STOP_EDGES   = 2;
	localparam int GEN_START_EDGES  = 2;
	localparam int MAX_GPCLK        = 4;

	// register byte offsets
	localparam logic [7:0] OFF_OSC_CTRL  = 8'h00;
	localparam logic [7:0] OFF_STATUS    = 8'h04;
	localparam logic [7:0] OFF_GEN_BASE  = 8'h08;
	localparam logic [7:0] REG_STRIDE    = 8'h04;
	localparam logic [7:0] OFF_FC_CTRL   = 8'h20;
	localparam logic [7:0] OFF_FC_RESULT = 8'h24;
	localparam logic [7:0] OFF_RESUS     = 8'h28;
	localparam logic [7:0] OFF_DEEP_STOP = 8'h2C;

	// field positions
	localparam int OSC_RING_EN_BIT   = 0;
	localparam int OSC_XTAL_EN_BIT   = 1;
	localparam int OSC_XTAL_PASS_BIT = 2;
	localparam int OSC_RING_CFG_LSB  = 8;
	localparam int GEN_SEL_LSB       = 0;
	localparam int GEN_DIV_LSB       = 8;
	localparam int GEN_EN_BIT        = 16;
	localparam int GEN_BUSY_BIT      = 17;
	localparam int FC_SEL_LSB        = 0;
	localparam int FC_START_BIT      = 8;
	localparam int RESUS_EN_BIT      = 0;
	localparam int RESUS_FLAG_BIT    = 16;
	localparam int DEEP_ENTER_BIT    = 0;
	localparam int SRC_VALID_BIT     = 3;

	// status register bits
	localparam int ST_RING = 0, ST_XTAL = 1, ST_STABLE = 2, ST_DEEP = 3, ST_SLEEP = 4;
	localparam int ST_LOCK0 = 5, ST_LOCK1 = 6, ST_RESUS = 7, ST_FC_BUSY = 8, ST_FC_DONE = 9;

	// reset values
	localparam logic [7:0] RING_CFG_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET      = 8'h01;

	// shared source vector positions
	localparam logic [2:0] SRC_RING = 3'h0, SRC_XTAL = 3'h1, SRC_EXT_A = 3'h2;
	localparam logic [2:0] SRC_EXT_B = 3'h3, SRC_PLL0 = 3'h4, SRC_PLL1 = 3'h5;
	localparam logic [2:0] SRC_REF = 3'h6, SRC_SYS = 3'h7;

	localparam int GEN_REF = 0;
	localparam int GEN_SYS = 1;
	localparam int GEN_GP0 = 2;

	typedef enum logic [1:0] {
		GEN_RUN   = 2'b00,
		GEN_STOP  = 2'b01,
		GEN_START = 2'b10
	} gen_state_e;

	typedef struct packed {
		logic       enable;
		logic [7:0] div;
		logic [2:0] sel;
	} gen_ctrl_s;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} avmm_req_s;

endpackage

// ===== design/clock_source_management.sv
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module clock_source_management
	import clk_mgmt_pkg::*;
#(
	parameter int XTAL_STARTUP_CYCLES = XTAL_STARTUP_CYC,
	parameter int NUM_GPCLK           = MAX_GPCLK
)
(
	// clock and reset
	input  wire logic                         core_clk_i,
	input  wire logic                         rst_n_i,
	// register bus
	input  wire clk_mgmt_pkg::avmm_req_s      avs_req_i,
	output logic [31:0]                       avs_readdata_o,
	output logic                              avs_waitrequest_o,
	// clock sources
	input  wire logic                         ring_osc_clk_i,
	input  wire logic                         crystal_osc_clk_i,
	input  wire logic                         crystal_in_pin_i,
	input  wire logic                         ext_clock_in_a_i,
	input  wire logic                         ext_clock_in_b_i,
	input  wire logic [1:0]                   pll_clk_i,
	input  wire logic [1:0]                   pll_lock_i,
	// power modes
	input  wire logic                         sleep_i,
	input  wire logic                         wake_rtc_alarm_i,
	input  wire logic                         wake_gpio_i,
	// oscillator control
	output logic                              ring_osc_enable_o,
	output logic [7:0]                        ring_osc_cfg_o,
	output logic                              crystal_osc_enable_o,
	output logic                              crystal_passthrough_o,
	output logic                              pll_ref_clk_o,
	output logic                              deep_stop_mode_o,
	// generated clocks
	output logic                              ref_clk_o,
	output logic                              sys_clk_o,
	output logic [NUM_GPCLK-1:0]              gpio_clock_outputs_o
);
	import clk_mgmt_pkg::*;

	localparam int NGEN = 2 + NUM_GPCLK;
	localparam int XW   = $clog2(XTAL_STARTUP_CYCLES + 1);
	localparam int RW   = $clog2(RESUS_CYC + 1);
	localparam int FW   = $clog2(FC_WINDOW_CYC + 1);

	if (NUM_GPCLK < 1 || NUM_GPCLK > MAX_GPCLK || XTAL_STARTUP_CYCLES < 1)
	begin : g_bad_param
		$error("clock_source_management: unsupported parameter value");
	end

	// ref and sys have their own source tables, gp generators select the shared vector directly; returns {valid, source position}
	function automatic logic [3:0] src_index(input int gen, input logic [2:0] sel);
		logic [3:0] r;
		r = {1'b0, SRC_RING};
		if (gen == GEN_REF)
		begin
			if (sel == 3'h0) r = {1'b1, SRC_RING};
			else if (sel == 3'h1) r = {1'b1, SRC_XTAL};
			else if (sel == 3'h2) r = {1'b1, SRC_EXT_A};
		end
		else if (gen == GEN_SYS)
		begin
			if (sel == 3'h0) r = {1'b1, SRC_REF};
			else if (sel == 3'h1) r = {1'b1, SRC_PLL0};
			else if (sel == 3'h2) r = {1'b1, SRC_PLL1};
			else if (sel == 3'h3) r = {1'b1, SRC_EXT_B};
		end
		else
			r = {1'b1, sel};
		return r;
	endfunction

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	function automatic logic [7:0] gen_addr(input int g);
		return OFF_GEN_BASE + 8'(g) * REG_STRIDE;
	endfunction

	// registers
	logic        ring_en, xtal_en, xtal_pass, xtal_stable, resus_en, resus_flag, resus_kick;
	logic [7:0]  ring_cfg;
	logic [2:0]  fc_sel;
	logic        fc_busy, fc_done;
	logic [31:0] fc_count, fc_result, rd_value, wr_word;
	logic [FW-1:0] fc_win;
	logic [XW-1:0] xtal_cnt;
	logic [RW-1:0] resus_cnt;
	gen_ctrl_s   gen_ctrl [NGEN];
	gen_state_e  gen_state [NGEN];
	logic [2:0]  gen_cur [NGEN];
	logic [1:0]  gen_edges [NGEN];
	logic [7:0]  gen_div_cnt [NGEN];
	logic        gen_tog [NGEN];
	logic        gen_out [NGEN];
	logic [3:0]  gen_src [NGEN];
	logic [NGEN-1:0] gen_rise, gen_edge;
	logic [7:0]  raw_src, src_prev, src_rise, src_edge;
	logic        xtal_src, wr_fire, fc_start;

	// read data loads when the request is taken, so only writes need a fire strobe
	assign wr_fire  = avs_req_i.write & ~avs_waitrequest_o;
	assign fc_start = wr_fire && avs_req_i.address == OFF_FC_CTRL
		&& avs_req_i.byteenable[1] && avs_req_i.writedata[FC_START_BIT];

	// pass-through pin is never gated; oscillator output is blocked until stable
	assign xtal_src = xtal_pass ? crystal_in_pin_i : (crystal_osc_clk_i & xtal_stable);
	// external inputs bypass the deep-stop gate, not the sleep gate on generator outputs
	assign raw_src  = {gen_out[GEN_SYS], gen_out[GEN_REF], pll_clk_i[1], pll_clk_i[0],
		ext_clock_in_b_i, ext_clock_in_a_i, xtal_src, ring_osc_clk_i};
	assign src_rise = raw_src & ~src_prev;
	assign src_edge = raw_src ^ src_prev;

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i) src_prev <= 8'h00;
		else src_prev <= raw_src;
	end

	always_comb
	begin
		for (int g = 0; g < NGEN; g++)
		begin
			gen_src[g]  = src_index(g, gen_cur[g]);
			gen_rise[g] = gen_src[g][SRC_VALID_BIT] & src_rise[gen_src[g][2:0]];
			gen_edge[g] = gen_src[g][SRC_VALID_BIT] & src_edge[gen_src[g][2:0]];
		end
	end

	// read mux
	always_comb
	begin
		rd_value = 32'h0000_0000;
		if (avs_req_i.address == OFF_OSC_CTRL)
		begin
			rd_value[OSC_RING_EN_BIT]   = ring_en;
			rd_value[OSC_XTAL_EN_BIT]   = xtal_en;
			rd_value[OSC_XTAL_PASS_BIT] = xtal_pass;
			rd_value[OSC_RING_CFG_LSB +: 8] = ring_cfg;
		end
		else if (avs_req_i.address == OFF_STATUS)
		begin
			rd_value[ST_RING]    = ring_osc_enable_o;
			rd_value[ST_XTAL]    = crystal_osc_enable_o;
			rd_value[ST_STABLE]  = xtal_stable;
			rd_value[ST_DEEP]    = deep_stop_mode_o;
			rd_value[ST_SLEEP]   = sleep_i;
			rd_value[ST_LOCK0]   = pll_lock_i[0];
			rd_value[ST_LOCK1]   = pll_lock_i[1];
			rd_value[ST_RESUS]   = resus_flag;
			rd_value[ST_FC_BUSY] = fc_busy;
			rd_value[ST_FC_DONE] = fc_done;
		end
		else if (avs_req_i.address == OFF_FC_CTRL)
			rd_value[FC_SEL_LSB +: 3] = fc_sel;
		else if (avs_req_i.address == OFF_FC_RESULT)
			rd_value = fc_result;
		else if (avs_req_i.address == OFF_RESUS)
		begin
			rd_value[RESUS_EN_BIT]   = resus_en;
			rd_value[RESUS_FLAG_BIT] = resus_flag;
		end
		else if (avs_req_i.address == OFF_DEEP_STOP)
			rd_value[DEEP_ENTER_BIT] = deep_stop_mode_o;
		else
		begin
			for (int g = 0; g < NGEN; g++)
				if (avs_req_i.address == gen_addr(g))
				begin
					rd_value[GEN_SEL_LSB +: 3] = gen_ctrl[g].sel;
					rd_value[GEN_DIV_LSB +: 8] = gen_ctrl[g].div;
					rd_value[GEN_EN_BIT]       = gen_ctrl[g].enable;
					rd_value[GEN_BUSY_BIT]     = gen_state[g] != GEN_RUN;
				end
		end
	end

	assign wr_word = merge_be(rd_value, avs_req_i.writedata, avs_req_i.byteenable);

	// bus handshake: one wait cycle, then the access completes
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
		end
		else if (!avs_waitrequest_o)
			avs_waitrequest_o <= 1'b1;
		else if (avs_req_i.read || avs_req_i.write)
		begin
			avs_waitrequest_o <= 1'b0;
			if (avs_req_i.read) avs_readdata_o <= rd_value;
		end
	end

	// software-written control registers
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ring_en   <= 1'b1;
			xtal_en   <= 1'b0;
			xtal_pass <= 1'b0;
			ring_cfg  <= RING_CFG_RESET;
			fc_sel    <= SRC_RING;
			resus_en  <= 1'b1;
			for (int g = 0; g < NGEN; g++)
			begin
				gen_ctrl[g].sel    <= 3'h0;
				gen_ctrl[g].div    <= DIV_RESET;
				gen_ctrl[g].enable <= g < GEN_GP0;
			end
		end
		else if (resus_kick)
		begin
			// fall back to ring -> ref -> sys, the path that works out of reset
			ring_en <= 1'b1;
			gen_ctrl[GEN_REF].sel <= 3'h0;
			gen_ctrl[GEN_SYS].sel <= 3'h0;
			gen_ctrl[GEN_REF].enable <= 1'b1;
			gen_ctrl[GEN_SYS].enable <= 1'b1;
		end
		else if (wr_fire)
		begin
			if (avs_req_i.address == OFF_OSC_CTRL)
			begin
				ring_en   <= wr_word[OSC_RING_EN_BIT];
				xtal_en   <= wr_word[OSC_XTAL_EN_BIT];
				xtal_pass <= wr_word[OSC_XTAL_PASS_BIT];
				ring_cfg  <= wr_word[OSC_RING_CFG_LSB +: 8];
			end
			else if (avs_req_i.address == OFF_FC_CTRL)
				fc_sel <= wr_word[FC_SEL_LSB +: 3];
			else if (avs_req_i.address == OFF_RESUS)
				resus_en <= wr_word[RESUS_EN_BIT];
			else
				for (int g = 0; g < NGEN; g++)
					if (avs_req_i.address == gen_addr(g))
					begin
						gen_ctrl[g].sel    <= wr_word[GEN_SEL_LSB +: 3];
						gen_ctrl[g].div    <= wr_word[GEN_DIV_LSB +: 8];
						gen_ctrl[g].enable <= wr_word[GEN_EN_BIT];
					end
		end
	end

	// deep stop: a wake in the same cycle as entry wins, so no wake is lost
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i) deep_stop_mode_o <= 1'b0;
		else if (wake_rtc_alarm_i || wake_gpio_i) deep_stop_mode_o <= 1'b0;
		else if (wr_fire && avs_req_i.address == OFF_DEEP_STOP
			&& avs_req_i.byteenable[0] && avs_req_i.writedata[DEEP_ENTER_BIT])
			deep_stop_mode_o <= 1'b1;
	end

	// oscillator enables drop in deep stop only; configuration is never touched
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ring_osc_enable_o     <= 1'b0;
			ring_osc_cfg_o        <= RING_CFG_RESET;
			crystal_osc_enable_o  <= 1'b0;
			crystal_passthrough_o <= 1'b0;
			pll_ref_clk_o         <= 1'b0;
		end
		else
		begin
			ring_osc_enable_o     <= ring_en & ~deep_stop_mode_o;
			ring_osc_cfg_o        <= ring_cfg;
			crystal_osc_enable_o  <= xtal_en & ~deep_stop_mode_o;
			crystal_passthrough_o <= xtal_pass;
			pll_ref_clk_o         <= xtal_src;
		end
	end

	// startup timer; restarts after every stop so deep-stop exit waits again
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			xtal_cnt    <= '0;
			xtal_stable <= 1'b0;
		end
		else if (!crystal_osc_enable_o)
		begin
			xtal_cnt    <= '0;
			xtal_stable <= 1'b0;
		end
		else if (xtal_cnt == XW'(XTAL_STARTUP_CYCLES))
			xtal_stable <= 1'b1;
		else
			xtal_cnt <= xtal_cnt + 1'b1;
	end

	// generators: stop on old source, restart on new, then divide and gate
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int g = 0; g < NGEN; g++)
			begin
				gen_state[g]   <= GEN_RUN;
				gen_cur[g]     <= 3'h0;
				gen_edges[g]   <= 2'h0;
				gen_div_cnt[g] <= 8'h00;
				gen_tog[g]     <= 1'b0;
				gen_out[g]     <= 1'b0;
			end
		end
		else
		begin
			for (int g = 0; g < NGEN; g++)
			begin
				gen_out[g] <= gen_tog[g] & gen_ctrl[g].enable & ~sleep_i
					& (gen_state[g] == GEN_RUN);
				if (resus_kick && g < GEN_GP0)
				begin
					// dead source cannot count out a stop, so skip it
					gen_cur[g]   <= 3'h0;
					gen_state[g] <= GEN_START;
					gen_edges[g] <= 2'h0;
					gen_tog[g]   <= 1'b0;
				end
				else
				case (gen_state[g])
				GEN_RUN:
					if (gen_ctrl[g].sel != gen_cur[g])
					begin
						gen_state[g] <= GEN_STOP;
						gen_edges[g] <= 2'h0;
					end
					else if (gen_edge[g])
					begin
						if (gen_div_cnt[g] + 8'h01 >= gen_ctrl[g].div)
						begin
							gen_div_cnt[g] <= 8'h00;
							gen_tog[g]     <= ~gen_tog[g];
						end
						else
							gen_div_cnt[g] <= gen_div_cnt[g] + 8'h01;
					end
				GEN_STOP:
				begin
					gen_tog[g] <= 1'b0;
					if (!gen_src[g][SRC_VALID_BIT] || (gen_rise[g]
						&& gen_edges[g] == 2'(GEN_STOP_EDGES - 1)))
					begin
						gen_cur[g]   <= gen_ctrl[g].sel;
						gen_state[g] <= GEN_START;
						gen_edges[g] <= 2'h0;
					end
					else if (gen_rise[g])
						gen_edges[g] <= gen_edges[g] + 2'h1;
				end
				GEN_START:
					if (gen_rise[g] && gen_edges[g] == 2'(GEN_START_EDGES - 1))
					begin
						gen_state[g]   <= GEN_RUN;
						gen_div_cnt[g] <= 8'h00;
					end
					else if (gen_rise[g])
						gen_edges[g] <= gen_edges[g] + 2'h1;
				default:
					gen_state[g] <= GEN_RUN;
				endcase
			end
		end
	end

	assign ref_clk_o = gen_out[GEN_REF];
	assign sys_clk_o = gen_out[GEN_SYS];
	for (genvar k = 0; k < NUM_GPCLK; k++)
	begin : g_gpout
		assign gpio_clock_outputs_o[k] = gen_out[GEN_GP0 + k];
	end

	// resuscitator: watch for sys edges; sleep and deep stop stop sys on purpose
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			resus_cnt  <= '0;
			resus_kick <= 1'b0;
			resus_flag <= 1'b0;
		end
		else
		begin
			resus_kick <= 1'b0;
			if (src_edge[SRC_SYS] || !resus_en || sleep_i || deep_stop_mode_o
				|| gen_state[GEN_SYS] != GEN_RUN || !gen_ctrl[GEN_SYS].enable)
				resus_cnt <= '0;
			else if (resus_cnt == RW'(RESUS_CYC - 1))
			begin
				resus_cnt  <= '0;
				resus_kick <= 1'b1;
			end
			else
				resus_cnt <= resus_cnt + 1'b1;
			// set wins over a same-cycle clear
			if (resus_kick)
				resus_flag <= 1'b1;
			else if (wr_fire && avs_req_i.address == OFF_RESUS && avs_req_i.byteenable[2]
				&& avs_req_i.writedata[RESUS_FLAG_BIT])
				resus_flag <= 1'b0;
		end
	end

	// frequency counter: rising edges of chosen source over a fixed window
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fc_busy <= 1'b0;
			fc_done <= 1'b0;
			fc_win  <= '0;
			fc_count  <= 32'h0000_0000;
			fc_result <= 32'h0000_0000;
		end
		else if (fc_start)
		begin
			fc_busy  <= 1'b1;
			fc_done  <= 1'b0;
			fc_win   <= '0;
			fc_count <= 32'h0000_0000;
		end
		else if (fc_busy)
		begin
			fc_count <= fc_count + 32'(src_rise[fc_sel]);
			fc_win   <= fc_win + 1'b1;
			if (fc_win == FW'(FC_WINDOW_CYC - 1))
			begin
				fc_busy   <= 1'b0;
				fc_done   <= 1'b1;
				fc_result <= fc_count + 32'(src_rise[fc_sel]);
			end
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_ring_deep_off: assert property (deep_stop_mode_o |=> !ring_osc_enable_o)
		else $error("ring oscillator running in deep stop");
	a_ring_cfg_kept: assert property ($fell(deep_stop_mode_o) && !$past(wr_fire)
		&& !$past(wr_fire, 2) |-> ring_osc_cfg_o == $past(ring_osc_cfg_o, 2))
		else $error("ring configuration lost across deep stop");
	a_ring_sleep_on: assert property (sleep_i && ring_en && !deep_stop_mode_o
		|=> ring_osc_enable_o)
		else $error("ring oscillator stopped by sleep");
	// stable clears one cycle after the enable drops, hence three cycles of deep stop
	a_xtal_deep_off: assert property (deep_stop_mode_o [*3]
		|-> !crystal_osc_enable_o && !xtal_stable)
		else $error("crystal running in deep stop");
	a_xtal_gated: assert property (!xtal_stable && !xtal_pass
		|-> !raw_src[SRC_XTAL] ##1 !pll_ref_clk_o)
		else $error("unstable crystal reached a generator");
	a_sleep_gates: assert property (sleep_i |=> !sys_clk_o && !ref_clk_o
		&& gpio_clock_outputs_o == '0)
		else $error("generator output during sleep");
	a_switch_two_edges: assert property ($changed(gen_cur[GEN_SYS])
		&& !$past(resus_kick) |-> $past(gen_state[GEN_SYS]) == GEN_STOP
		&& ($past(gen_edges[GEN_SYS]) == 2'h1 || !$past(gen_src[GEN_SYS][SRC_VALID_BIT])))
		else $error("source switched before old source stopped");
	a_resus_restart: assert property (resus_kick |=> gen_cur[GEN_SYS] == 3'h0
		&& gen_state[GEN_SYS] == GEN_START && resus_flag && ring_en)
		else $error("system clock not resuscitated");
	a_deep_wake: assert property ((wake_rtc_alarm_i || wake_gpio_i)
		|=> !deep_stop_mode_o ##1 ring_osc_enable_o == ring_en)
		else $error("wake did not end deep stop");
	a_fc_window: assert property (fc_start |=> fc_busy [*8])
		else $error("frequency window ended early");

	c_deep_cycle: cover property (deep_stop_mode_o ##[1:20] !deep_stop_mode_o);
	c_resus: cover property (resus_kick);
	c_switch_done: cover property (gen_state[GEN_SYS] == GEN_START ##[1:50]
		gen_state[GEN_SYS] == GEN_RUN);
	c_fc_done: cover property ($rose(fc_done));

endmodule

// ===== verification/osc_partner.sv
`timescale 1ns/1ns
module osc_partner
(
	// oscillator control
	input  wire logic       ring_en_i,
	input  wire logic       xtal_en_i,
	input  wire logic       ext_b_run_i,
	// clocks
	output logic            ring_clk_o,
	output logic            xtal_clk_o,
	output logic            xtal_pin_clk_o,
	output logic            ext_a_o,
	output logic            ext_b_o,
	output logic [1:0]      pll_clk_o,
	output logic [1:0]      pll_lock_o
);
	initial
	begin
		ring_clk_o = 1'b0;
		xtal_clk_o = 1'b0;
		xtal_pin_clk_o = 1'b0;
		ext_a_o = 1'b0;
		ext_b_o = 1'b0;
		pll_clk_o = 2'b00;
		pll_lock_o = 2'b00;
		#300 pll_lock_o = 2'b11;
	end
	// even half periods keep every edge off the core sampling edge
	always #40 ring_clk_o = ring_en_i ? ~ring_clk_o : 1'b0;
	always #42 xtal_clk_o = xtal_en_i ? ~xtal_clk_o : 1'b0;
	always #44 xtal_pin_clk_o = ~xtal_pin_clk_o;
	always #50 ext_a_o = ~ext_a_o;
	always #30 ext_b_o = ext_b_run_i ? ~ext_b_o : 1'b0;
	// no reference, no pll output
	always #10 pll_clk_o = xtal_en_i ? ~pll_clk_o : 2'b00;
endmodule

// ===== verification/tb_clock_source_management.sv
`timescale 1ns/1ns
module tb_clock_source_management;
	import clk_mgmt_pkg::*;
	logic        core_clk_i;
	logic        rst_n_i;
	avmm_req_s   req;
	logic [31:0] rdata;
	logic        wait_req;
	logic        ring_clk, xtal_clk, pin_clk, ext_a, ext_b, ext_b_run;
	logic [1:0]  pll_clk, pll_lock;
	logic        sleep, wake_rtc, wake_gpio;
	logic        ring_en, xtal_en, pass, pll_ref, deep, ref_clk, sys_clk;
	logic [7:0]  ring_cfg, cfg;
	logic [3:0]  gp_clk;
	logic [31:0] q, seed;
	int          mismatches, num_checks, cnt;

	clock_source_management #(.XTAL_STARTUP_CYCLES(20), .NUM_GPCLK(4)) clock_source_management_inst
	(
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_req_i(req), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_req), .ring_osc_clk_i(ring_clk), .crystal_osc_clk_i(xtal_clk),
		.crystal_in_pin_i(pin_clk), .ext_clock_in_a_i(ext_a), .ext_clock_in_b_i(ext_b),
		.pll_clk_i(pll_clk), .pll_lock_i(pll_lock), .sleep_i(sleep), .wake_rtc_alarm_i(wake_rtc),
		.wake_gpio_i(wake_gpio), .ring_osc_enable_o(ring_en), .ring_osc_cfg_o(ring_cfg),
		.crystal_osc_enable_o(xtal_en), .crystal_passthrough_o(pass), .pll_ref_clk_o(pll_ref),
		.deep_stop_mode_o(deep), .ref_clk_o(ref_clk), .sys_clk_o(sys_clk),
		.gpio_clock_outputs_o(gp_clk)
	);

	osc_partner osc_partner_inst
	(
		.ring_en_i(ring_en), .xtal_en_i(xtal_en), .ext_b_run_i(ext_b_run), .ring_clk_o(ring_clk),
		.xtal_clk_o(xtal_clk), .xtal_pin_clk_o(pin_clk), .ext_a_o(ext_a), .ext_b_o(ext_b),
		.pll_clk_o(pll_clk), .pll_lock_o(pll_lock)
	);

	initial core_clk_i = 1'b0;
	always #5 core_clk_i = ~core_clk_i;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic pick(input int w);
		case (w)
			0: return ref_clk;
			1: return sys_clk;
			2: return gp_clk[0];
			default: return pll_ref;
		endcase
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk_i);
		req <= '{read: rd, write: !rd, address: a, writedata: d, byteenable: 4'hf};
		n = 0;
		do
		begin
			@(posedge core_clk_i);
			n++;
		end
		while (wait_req !== 1'b0 && n < 50);
		q = rdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		if (n >= 50)
			check(32'h0, 32'h1);
	endtask

	// toggles of one generated clock, or of pll_ref, over 100 core cycles
	task automatic toggles(input int w, output int c);
		logic last;
		c = 0;
		last = pick(w);
		repeat (100)
		begin
			@(posedge core_clk_i);
			if (pick(w) !== last)
				c++;
			last = pick(w);
		end
	endtask

	task end_of_test;
		if (mismatches == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		mismatches++;
		end_of_test;
	end

	initial
	begin
		rst_n_i = 1'b0;
		req = '0;
		sleep = 1'b0;
		wake_rtc = 1'b0;
		wake_gpio = 1'b0;
		ext_b_run = 1'b1;
		seed = 32'hafa4;
		repeat (6) @(posedge core_clk_i);
		check({31'h0, wait_req}, 32'h1);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		check({31'h0, ring_en}, 32'h1);
		check({31'h0, xtal_en}, 32'h0);
		bus(1'b1, OFF_OSC_CTRL, 32'h0);
		check(q, 32'h0000_0001);
		bus(1'b1, 8'h3C, 32'h0);
		check(q, 32'h0000_0000);
		repeat (4)
		begin
			seed = lfsr(seed);
			cfg = seed[7:0];
			bus(1'b0, OFF_OSC_CTRL, {16'h0, cfg, 8'h03});
			bus(1'b1, OFF_OSC_CTRL, 32'h0);
			check(q, {16'h0, cfg, 8'h03});
			check({24'h0, ring_cfg}, {24'h0, cfg});
		end
		bus(1'b1, OFF_STATUS, 32'h0);
		check(q, 32'h0000_0067);
		// ring slowed before sleep in case it runs near a limit
		cfg = cfg >> 1;
		bus(1'b0, OFF_OSC_CTRL, {16'h0, cfg, 8'h03});
		sleep <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		check({22'h0, ring_en, xtal_en, ring_cfg}, {22'h0, 2'b11, cfg});
		toggles(0, cnt);
		check(32'(cnt), 32'h0);
		sleep <= 1'b0;
		bus(1'b0, OFF_OSC_CTRL, {16'h0, cfg, 8'h07});
		bus(1'b0, OFF_DEEP_STOP, 32'h0000_0001);
		repeat (3) @(posedge core_clk_i);
		check({28'h0, pass, deep, ring_en, xtal_en}, 32'h0000_000C);
		toggles(3, cnt);
		check(32'(cnt > 0), 32'h1);
		seed = lfsr(seed);
		wake_rtc <= seed[0];
		wake_gpio <= !seed[0];
		repeat (2) @(posedge core_clk_i);
		wake_rtc <= 1'b0;
		wake_gpio <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		check({21'h0, deep, ring_en, xtal_en, ring_cfg}, {21'h0, 3'b011, cfg});
		bus(1'b0, OFF_FC_CTRL, 32'h0000_0102);
		repeat (1010) @(posedge core_clk_i);
		bus(1'b1, OFF_FC_RESULT, 32'h0);
		check(32'(q >= 99 && q <= 101), 32'h1);
		bus(1'b0, OFF_GEN_BASE + 8'h08, 32'h0001_0100);
		repeat (30) @(posedge core_clk_i);
		toggles(2, cnt);
		check(32'(cnt > 0), 32'h1);
		check({29'h0, gp_clk[3:1]}, 32'h0000_0000);
		bus(1'b0, OFF_GEN_BASE + REG_STRIDE, 32'h0001_0103);
		repeat (60) @(posedge core_clk_i);
		ext_b_run <= 1'b0;
		repeat (300) @(posedge core_clk_i);
		bus(1'b1, OFF_STATUS, 32'h0);
		check({31'h0, q[7]}, 32'h1);
		toggles(1, cnt);
		check(32'(cnt > 0), 32'h1);
		bus(1'b0, OFF_RESUS, 32'h0001_0001);
		bus(1'b1, OFF_RESUS, 32'h0);
		check(q, 32'h0000_0001);
		// ref leaves the ring first, so stopping the ring keeps sys alive
		bus(1'b0, OFF_GEN_BASE, 32'h0001_0102);
		repeat (60) @(posedge core_clk_i);
		bus(1'b0, OFF_OSC_CTRL, {16'h0, cfg, 8'h06});
		repeat (3) @(posedge core_clk_i);
		check({31'h0, ring_en}, 32'h0);
		toggles(1, cnt);
		check(32'(cnt > 0), 32'h1);
		end_of_test;
	end
endmodule
